// [bench/afe_host_model.sv]
/* Host side model driving the register strobe port.
   Assumes ack follows every strobe within a few cycles. */
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
	input  wire logic        ref_clk,
	output logic [7:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack
);
	int lost_acks = 0; // Strobes that never saw an ack
	// Idle bus values at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One strobe cycle, then wait for ack; released bus shows the inverse
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (reg_ack !== 1'b1 && n < 8);
		if (n >= 8) lost_acks++;
		q = reg_rdata;
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic read(input logic [7:0] a, output logic [15:0] q);
		access(1'b0, a, 16'h0000, q);
	endtask
	// Direct mode: buffer bit first, then the companion bit if buffered, code last
	task automatic direct_path(input logic buffered);
		logic [15:0] v;
		read(8'h42, v);
		v[7] = buffered;
		write(8'h42, v);
		if (buffered) begin
			write(8'h58, 16'h0080);
			write(8'h43, 16'hAE65);
		end else begin
			write(8'h43, 16'hB065);
		end
	endtask
endmodule
`default_nettype wire

// [bench/afe_slot_integration_config_assertions.sv]
/* Port checker for the slot front end configuration block.
   Assumes one ref_clk domain and a synchronous active low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "afe_slot_config_defs.svh"
module afe_slot_integration_config_assertions (
	input wire logic                   ref_clk,
	input wire logic                   reset_n,
	input wire logic                   ce,
	input wire logic [`REG_ADDR_W-1:0] reg_addr,
	input wire logic [`REG_DATA_W-1:0] reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [`REG_DATA_W-1:0] reg_rdata,
	input wire logic                   slot_b_slot_start,
	input wire logic                   slot_b_pulse_start,
	input wire logic                   slot_b_integ_reversed,
	input wire logic                   slot_b_window_open,
	input wire logic [7:0]             slot_a_channel_gain,
	input wire logic [31:0]            slot_a_channel_gain_kohm,
	input wire logic [10:0]            slot_a_amp_reference_mv,
	input wire logic                   slot_a_full_path,
	input wire logic                   slot_a_amp_direct,
	input wire logic                   slot_a_path_reserved
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] pol_reg; // Shadow of the stored polarity bits
	logic [1:0] idx_reg; // Pulse index, zero is pulse 1
	logic       cur_pol; // Polarity of the next pulse
	assign cur_pol = pol_reg[idx_reg];
	// Shadow state follows ce so a frozen design is not flagged
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pol_reg <= 4'h0;
			idx_reg <= 2'h0;
		end else if (ce) begin
			if (reg_wr && reg_addr == `ADDR_SLOT_B_POLARITY) pol_reg <= reg_wdata[3:0];
			if (slot_b_slot_start) idx_reg <= 2'h0;
			else if (slot_b_pulse_start) idx_reg <= idx_reg + 2'h1;
		end
	end
	sequence path_write;
		ce && reg_wr && reg_addr == `ADDR_SLOT_A_PATH;
	endsequence
	sequence path_read;
		ce && reg_rd && reg_addr == `ADDR_SLOT_A_PATH;
	endsequence
	sequence pulse_taken;
		ce && slot_b_pulse_start && !slot_b_slot_start;
	endsequence
	AST_PATH_ONEHOT: assert property ($onehot({slot_a_full_path, slot_a_amp_direct, slot_a_path_reserved}))
		else $error("path flags not one-hot");
	AST_PATH_DECODE: assert property (path_write ##1 ce |=> slot_a_full_path == ($past(reg_wdata, 2) == 16'hADA5))
		else $error("full path flag wrong after code write");
	AST_PATH_READBACK: assert property (path_write ##3 path_read |=> reg_rdata == $past(reg_wdata, 4))
		else $error("path code readback wrong");
	AST_POLARITY: assert property (pulse_taken |=> slot_b_integ_reversed == $past(cur_pol))
		else $error("pulse polarity wrong");
	AST_SLOT_START: assert property (ce && slot_b_slot_start |=> $stable(slot_b_integ_reversed))
		else $error("slot start changed polarity");
	AST_WINDOW_START: assert property (pulse_taken |=> !slot_b_window_open)
		else $error("window open right after pulse start");
	AST_REFERENCE: assert property (slot_a_amp_reference_mv inside {11'h474, 11'h3F2, 11'h384, 11'h4F6})
		else $error("reference voltage out of table");
	AST_GAIN_KOHM: assert property (slot_a_channel_gain_kohm[7:0] == (8'hC8 >> slot_a_channel_gain[1:0])
		&& slot_a_channel_gain_kohm[31:24] == (8'hC8 >> slot_a_channel_gain[7:6]))
		else $error("gain decode wrong");
endmodule
bind afe_slot_integration_config afe_slot_integration_config_assertions u_chk (.ref_clk(ref_clk),
	.reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .slot_b_slot_start(slot_b_slot_start), .slot_b_pulse_start(slot_b_pulse_start),
	.slot_b_integ_reversed(slot_b_integ_reversed), .slot_b_window_open(slot_b_window_open),
	.slot_a_channel_gain(slot_a_channel_gain), .slot_a_channel_gain_kohm(slot_a_channel_gain_kohm),
	.slot_a_amp_reference_mv(slot_a_amp_reference_mv), .slot_a_full_path(slot_a_full_path),
	.slot_a_amp_direct(slot_a_amp_direct), .slot_a_path_reserved(slot_a_path_reserved));
`default_nettype wire

// [bench/tb_afe_slot_integration_config.sv]
/* Self-checking bench for the slot front end configuration block.
   Assumes the checker is bound and the host model drives the port. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_afe_slot_integration_config;
	logic        ref_clk, reset_n, ce;       // Clock, reset, enable
	logic [5:0]  ch234;                      // External gain codes
	logic        slot_start, pulse_start;    // Sequencing strobes
	logic [7:0]  reg_addr;                   // Register port
	logic [15:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, reg_ack;
	logic        rev, win_open, win_done;    // Slot B outputs
	logic [5:0]  mode;
	logic [7:0]  gain;                       // Slot A outputs
	logic [31:0] kohm;
	logic [10:0] ref_mv;
	logic        as_buf, full, direct, rsv, misc;
	int          miscompares = 0, checked = 0;  // Verdict counters
	logic [31:0] lfsr_state;                 // Random source
	afe_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
	afe_slot_integration_config dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.slot_a_ch234_gain(ch234), .slot_b_slot_start(slot_start), .slot_b_pulse_start(pulse_start),
		.slot_b_integ_reversed(rev), .slot_b_window_open(win_open), .slot_b_window_done(win_done),
		.slot_b_front_end_mode_field(mode), .slot_a_channel_gain(gain), .slot_a_channel_gain_kohm(kohm),
		.slot_a_amp_reference_mv(ref_mv), .slot_a_integrator_as_buffer(as_buf), .slot_a_full_path(full),
		.slot_a_amp_direct(direct), .slot_a_path_reserved(rsv), .slot_a_path_misconfig(misc));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [10:0] ref_exp(input logic [1:0] c);
		case (c)
			2'h0: return 11'h474;
			2'h1: return 11'h3F2;
			2'h2: return 11'h384;
			default: return 11'h4F6;
		endcase
	endfunction
	function automatic logic [31:0] kohm_exp(input logic [7:0] g);
		logic [31:0] k;
		for (int c = 0; c < 4; c++) k[8*c+:8] = 8'hC8 >> g[2*c+:2];
		return k;
	endfunction
	// Window edges land on the first clock at or after the exact time
	function automatic int edge_exp(input int ps);
		return (ps + 49999) / 50000 + 1;
	endfunction
	// 50 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic drive(input logic ps, input logic ss);
		@(posedge ref_clk);
		pulse_start <= ps;
		slot_start <= ss;
		@(posedge ref_clk);
		pulse_start <= 1'b0;
		slot_start <= 1'b0;
		#1;
	endtask
	task automatic chk_path(input logic f, input logic d, input logic r, input logic m);
		repeat (2) @(posedge ref_clk);
		`CHECK({full, direct, rsv, misc}, {f, d, r, m});
	endtask
	task automatic wrap_up;
		`CHECK(host.lost_acks, 0);
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Hang guard, far past a run of a few thousand cycles
	initial begin
		#2000000;
		miscompares++;
		wrap_up();
	end
	initial begin
		logic [7:0]  addrs [5];
		logic [15:0] rsts [5];
		logic [15:0] v, q, code;
		logic [3:0]  p;
		logic        prev;
		logic [4:0]  w;
		logic [10:0] off;
		int          k;
		addrs = '{8'h1D, 8'h3B, 8'h42, 8'h43, 8'h44};
		rsts = '{16'h0000, {5'h04, 11'h001}, 16'h1C38, 16'hADA5, 16'h1C38};
		lfsr_state = 32'h3A35;
		reset_n = 1'b0;
		ce = 1'b1;
		ch234 = 6'h00;
		slot_start = 1'b0;
		pulse_start = 1'b0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		// Reset values, plus an unmapped read
		for (int i = 0; i < 5; i++) begin
			host.read(addrs[i], q);
			`CHECK(q, rsts[i]);
		end
		host.read(8'h50, q);
		`CHECK(q, 16'h0000);
		`CHECK({full, ref_mv, kohm, mode}, {1'b1, 11'h4F6, 32'hC8C8C8C8, 6'h07});
		$display("test defaults done");
		// Random amplifier settings, individual enable toggled each pass
		for (int i = 0; i < 8; i++) begin
			lfsr_state = lfsr_next(lfsr_state);
			v = lfsr_state[15:0];
			v[6] = i[0];
			ch234 <= lfsr_state[21:16];
			host.write(8'h42, v);
			host.read(8'h42, q);
			repeat (2) @(posedge ref_clk);
			`CHECK(q, v);
			code = {8'h00, (v[6] ? ch234 : {3{v[1:0]}}), v[1:0]};
			`CHECK(gain, code[7:0]);
			`CHECK(kohm, kohm_exp(code[7:0]));
			`CHECK(ref_mv, ref_exp(v[5:4]));
			`CHECK(as_buf, v[7]);
		end
		$display("test amplifier done");
		// Both direct path codes, a reserved one, then the full path code
		host.direct_path(1'b1);
		chk_path(1'b0, 1'b1, 1'b0, 1'b0);
		host.direct_path(1'b0);
		chk_path(1'b0, 1'b1, 1'b0, 1'b0);
		host.write(8'h43, 16'hAE65);
		chk_path(1'b0, 1'b1, 1'b0, 1'b1);
		lfsr_state = lfsr_next(lfsr_state);
		code = lfsr_state[15:0];
		if (code inside {16'hADA5, 16'hAE65, 16'hB065}) code = code ^ 16'h0001;
		host.write(8'h43, code);
		host.read(8'h43, q);
		`CHECK(q, code);
		chk_path(1'b0, 1'b0, 1'b1, 1'b0);
		host.write(8'h43, 16'hADA5);
		chk_path(1'b1, 1'b0, 1'b0, 1'b0);
		$display("test path done");
		// Polarity sequence over more than four pulses
		for (int r = 0; r < 2; r++) begin
			lfsr_state = lfsr_next(lfsr_state);
			p = (r == 0) ? 4'hA : lfsr_state[3:0];
			host.write(8'h1D, {lfsr_state[15:4], p});
			host.read(8'h1D, q);
			`CHECK(q, {12'h000, p});
			drive(1'b0, 1'b1);
			for (int i = 0; i < 6; i++) begin
				lfsr_state = lfsr_next(lfsr_state);
				repeat (lfsr_state[1:0]) @(posedge ref_clk);
				drive(1'b1, 1'b0);
				`CHECK(rev, p[i%4]);
			end
			prev = rev;
			drive(1'b1, 1'b1);
			`CHECK(rev, prev);
			drive(1'b1, 1'b0);
			`CHECK(rev, p[0]);
		end
		$display("test polarity done");
		// Window timing: default, zero offset, random, largest offset
		repeat (90) @(posedge ref_clk);
		for (int j = 0; j < 4; j++) begin
			lfsr_state = lfsr_next(lfsr_state);
			case (j)
				0: begin w = 5'h04; off = 11'h001; end
				1: begin w = 5'h01; off = 11'h000; end
				2: begin w = {3'h0, lfsr_state[1:0]} + 5'h01; off = {5'h00, lfsr_state[7:2]}; end
				default: begin w = 5'h02; off = 11'h7FF; end
			endcase
			if (j > 0) host.write(8'h3B, {w, off});
			drive(1'b1, 1'b0);
			k = 0;
			while (win_open !== 1'b1 && k < 3000) begin
				@(posedge ref_clk);
				#1;
				k++;
			end
			`CHECK(k, edge_exp(off * 31250));
			while (win_open === 1'b1 && k < 3000) begin
				@(posedge ref_clk);
				#1;
				k++;
			end
			`CHECK(k, edge_exp(off * 31250 + w * 1000000));
			`CHECK(win_done, 1'b1);
		end
		$display("test window done");
		wrap_up();
	end
endmodule
`default_nettype wire

// [src/afe_slot_config_defs.svh]
/*
  Register offsets, field positions, reset values and timing figures
  for the per-slot front end configuration block.
  Assumes it is included by bare name from the design files.
*/
`ifndef AFE_SLOT_CONFIG_DEFS_SVH
`define AFE_SLOT_CONFIG_DEFS_SVH

// Register port widths
`define REG_ADDR_W            8
`define REG_DATA_W            16

// Register offsets
`define ADDR_SLOT_B_POLARITY  8'h1D
`define ADDR_SLOT_B_WINDOW    8'h3B
`define ADDR_SLOT_A_AMP       8'h42
`define ADDR_SLOT_A_PATH      8'h43
`define ADDR_SLOT_B_MODE      8'h44

// Reset values
`define RST_SLOT_B_POLARITY   16'h0000
`define RST_SLOT_B_WINDOW     16'h2001
`define RST_SLOT_A_AMP        16'h1C38
`define RST_SLOT_A_PATH       16'hADA5
`define RST_SLOT_B_MODE       16'h1C38

// Bits that hold storage in the polarity register; the rest read zero
`define POLARITY_STORE_MASK   16'h000F

// Field positions
`define POL_MSB               3
`define WIDTH_MSB             15
`define WIDTH_LSB             11
`define OFFSET_MSB            10
`define INT_AS_BUF_BIT        7
`define IND_EN_BIT            6
`define VREF_MSB              5
`define VREF_LSB              4
`define GAIN_MSB              1

// Path connection codes
`define PATH_CODE_FULL        16'hADA5
`define PATH_CODE_DIRECT_BUF  16'hAE65
`define PATH_CODE_DIRECT      16'hB065

// Timing, all in picoseconds (ref_clk 20 MHz, 31.25 ns offset step, 1 us width step)
`define TIME_W                28
`define CLK_PERIOD_PS         28'd50000
`define OFFSET_STEP_PS        28'd31250
`define WIDTH_STEP_PS         28'd1000000

`endif

// [src/afe_slot_config_pkg.sv]
/*
  Types shared by the front end configuration block and its window timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package afe_slot_config_pkg;

	// Decoded slot A analog path connection
	typedef enum logic [1:0] {
		PATH_FULL,
		PATH_DIRECT_BUF,
		PATH_DIRECT,
		PATH_RESERVED
	} path_mode_type;

	// Integration window timer states
	typedef enum logic [1:0] {
		WIN_IDLE,
		WIN_OFFSET,
		WIN_INTEGRATE
	} window_state_type;

endpackage

// [src/afe_slot_integration_config.sv]
/*
  Front end configuration for time slots A and B: register file reached
  through a simple synchronous register port, slot A amplifier and path
  decode, slot B pulse polarity sequencing and integration window timing.
  Assumes the serial control port outside turns host transactions into
  single-cycle reg_wr / reg_rd strobes synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afe_slot_config_defs.svh"

module afe_slot_integration_config (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   ce,
	input  wire logic [`REG_ADDR_W-1:0] reg_addr,
	input  wire logic [`REG_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [`REG_DATA_W-1:0] reg_rdata,
	output logic                        reg_ack,
	input  wire logic [5:0]             slot_a_ch234_gain,
	input  wire logic                   slot_b_slot_start,
	input  wire logic                   slot_b_pulse_start,
	output logic                        slot_b_integ_reversed,
	output logic                        slot_b_window_open,
	output logic                        slot_b_window_done,
	output logic [5:0]                  slot_b_front_end_mode_field,
	output logic [7:0]                  slot_a_channel_gain,
	output logic [31:0]                 slot_a_channel_gain_kohm,
	output logic [10:0]                 slot_a_amp_reference_mv,
	output logic                        slot_a_integrator_as_buffer,
	output logic                        slot_a_full_path,
	output logic                        slot_a_amp_direct,
	output logic                        slot_a_path_reserved,
	output logic                        slot_a_path_misconfig
);

	// Stored registers
	logic [`REG_DATA_W-1:0] slot_b_integration_polarity_reg;  // Pulse polarity pattern
	logic [`REG_DATA_W-1:0] slot_b_integration_window_reg;    // Width and offset
	logic [`REG_DATA_W-1:0] slot_a_amplifier_settings_reg;    // Mode, buffer, gain, reference
	logic [`REG_DATA_W-1:0] slot_a_path_connection_reg;       // Path code
	logic [`REG_DATA_W-1:0] slot_b_front_end_mode_reg;        // Slot B mode and amplifier

	// Field views
	logic [3:0]  slot_b_pulse_polarity;
	logic [4:0]  slot_b_window_width;
	logic [10:0] slot_b_window_offset;
	logic [15:0] slot_a_path_code;
	logic [1:0]  slot_a_amp_gain;
	logic [1:0]  slot_a_amp_reference;
	logic        slot_a_individual_gain_enable;

	// Sequencing state, read mux, path decode and gain selection
	logic [1:0]  pulse_index_reg;        // Which of the four pulses comes next
	logic        integ_reversed_reg;     // Polarity of the pulse in progress
	logic [`REG_DATA_W-1:0] rdata_next;  // Read mux
	afe_slot_config_pkg::path_mode_type path_mode;  // Decoded path
	logic [7:0]  channel_gain_next;      // Per-channel gain codes

	window_timing_if tif ();

	// Gain code to kOhm
	function automatic logic [7:0] gain_kohm(input logic [1:0] code);
		case (code)
			2'h0:    gain_kohm = 8'hC8;  // 200 kOhm
			2'h1:    gain_kohm = 8'h64;  // 100 kOhm
			2'h2:    gain_kohm = 8'h32;  // 50 kOhm
			default: gain_kohm = 8'h19;  // 25 kOhm
		endcase
	endfunction

	// Reference code to millivolts
	function automatic logic [10:0] vref_mv(input logic [1:0] code);
		case (code)
			2'h0:    vref_mv = 11'h474;  // 1.14 V
			2'h1:    vref_mv = 11'h3F2;  // 1.01 V
			2'h2:    vref_mv = 11'h384;  // 0.90 V
			default: vref_mv = 11'h4F6;  // 1.27 V
		endcase
	endfunction

	// Path code to mode
	function automatic afe_slot_config_pkg::path_mode_type decode_path(input logic [15:0] code);
		case (code)
			`PATH_CODE_FULL:       decode_path = afe_slot_config_pkg::PATH_FULL;
			`PATH_CODE_DIRECT_BUF: decode_path = afe_slot_config_pkg::PATH_DIRECT_BUF;
			`PATH_CODE_DIRECT:     decode_path = afe_slot_config_pkg::PATH_DIRECT;
			default:               decode_path = afe_slot_config_pkg::PATH_RESERVED;
		endcase
	endfunction

	// Field extraction
	assign slot_b_pulse_polarity         = slot_b_integration_polarity_reg[`POL_MSB:0];
	assign slot_b_window_width           = slot_b_integration_window_reg[`WIDTH_MSB:`WIDTH_LSB];
	assign slot_b_window_offset          = slot_b_integration_window_reg[`OFFSET_MSB:0];
	assign slot_a_path_code              = slot_a_path_connection_reg;
	assign slot_a_amp_gain               = slot_a_amplifier_settings_reg[`GAIN_MSB:0];
	assign slot_a_amp_reference          = slot_a_amplifier_settings_reg[`VREF_MSB:`VREF_LSB];
	assign slot_a_individual_gain_enable = slot_a_amplifier_settings_reg[`IND_EN_BIT];
	assign path_mode                     = decode_path(slot_a_path_code);

	// Register writes; every stored register except the polarity register is read/write in full
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			slot_b_integration_polarity_reg <= `RST_SLOT_B_POLARITY;
			slot_b_integration_window_reg   <= `RST_SLOT_B_WINDOW;
			slot_a_amplifier_settings_reg   <= `RST_SLOT_A_AMP;
			slot_a_path_connection_reg      <= `RST_SLOT_A_PATH;
			slot_b_front_end_mode_reg       <= `RST_SLOT_B_MODE;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				`ADDR_SLOT_B_POLARITY: begin
					// Upper bits are reserved and hold no storage
					slot_b_integration_polarity_reg <= reg_wdata & `POLARITY_STORE_MASK;
				end
				`ADDR_SLOT_B_WINDOW: begin
					slot_b_integration_window_reg <= reg_wdata;
				end
				`ADDR_SLOT_A_AMP: begin
					slot_a_amplifier_settings_reg <= reg_wdata;
				end
				`ADDR_SLOT_A_PATH: begin
					// Reserved codes are stored as written and flagged, not refused
					slot_a_path_connection_reg <= reg_wdata;
				end
				`ADDR_SLOT_B_MODE: begin
					slot_b_front_end_mode_reg <= reg_wdata;
				end
				default: begin
					// Unmapped writes are dropped
					slot_b_integration_polarity_reg <= slot_b_integration_polarity_reg;
				end
			endcase
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		case (reg_addr)
			`ADDR_SLOT_B_POLARITY: rdata_next = slot_b_integration_polarity_reg;
			`ADDR_SLOT_B_WINDOW:   rdata_next = slot_b_integration_window_reg;
			`ADDR_SLOT_A_AMP:      rdata_next = slot_a_amplifier_settings_reg;
			`ADDR_SLOT_A_PATH:     rdata_next = slot_a_path_connection_reg;
			`ADDR_SLOT_B_MODE:     rdata_next = slot_b_front_end_mode_reg;
			default:               rdata_next = '0;
		endcase
	end

	// Read data and acknowledge, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			reg_rdata <= '0;
			reg_ack   <= 1'b0;
		end else if (ce) begin
			reg_ack <= reg_wr | reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// Slot B pulse sequencing: the index picks the polarity bit for the
	// pulse that is starting, and wraps after the fourth pulse
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pulse_index_reg    <= 2'h0;
			integ_reversed_reg <= 1'b0;
		end else if (ce) begin
			if (slot_b_slot_start) begin
				// A new slot always begins at pulse 1
				pulse_index_reg <= 2'h0;
			end else if (slot_b_pulse_start) begin
				integ_reversed_reg <= slot_b_pulse_polarity[pulse_index_reg];
				pulse_index_reg    <= pulse_index_reg + 2'h1;
			end
		end
	end

	// Window timer hookup
	assign tif.window_offset = slot_b_window_offset;
	assign tif.window_width  = slot_b_window_width;
	assign tif.pulse_start   = slot_b_pulse_start & ~slot_b_slot_start;

	integration_window_timer window_timer (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.ce      (ce),
		.tif     (tif.timer)
	);

	// Channel gain selection; channels 2-4 take the external individual
	// codes only while the individual enable is set
	always_comb begin
		channel_gain_next[1:0] = slot_a_amp_gain;
		for (int ch = 1; ch < 4; ch++) begin
			if (slot_a_individual_gain_enable) begin
				channel_gain_next[2*ch +: 2] = slot_a_ch234_gain[2*(ch-1) +: 2];
			end else begin
				channel_gain_next[2*ch +: 2] = slot_a_amp_gain;
			end
		end
	end

	// Registered per-channel gain code and its kOhm value
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gain_chan
			always_ff @(posedge ref_clk) begin
				if (!reset_n) begin
					slot_a_channel_gain[2*g +: 2]      <= 2'h0;
					slot_a_channel_gain_kohm[8*g +: 8] <= gain_kohm(2'h0);
				end else if (ce) begin
					slot_a_channel_gain[2*g +: 2]      <= channel_gain_next[2*g +: 2];
					slot_a_channel_gain_kohm[8*g +: 8] <= gain_kohm(channel_gain_next[2*g +: 2]);
				end
			end
		end
	endgenerate

	// Amplifier reference and integrator mode
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			slot_a_amp_reference_mv     <= vref_mv(2'h3);
			slot_a_integrator_as_buffer <= 1'b0;
		end else if (ce) begin
			slot_a_amp_reference_mv     <= vref_mv(slot_a_amp_reference);
			slot_a_integrator_as_buffer <= slot_a_amplifier_settings_reg[`INT_AS_BUF_BIT];
		end
	end

	// Path decode; the misconfig flag only reports a host ordering slip,
	// the path still follows the written code
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			slot_a_full_path      <= 1'b1;
			slot_a_amp_direct     <= 1'b0;
			slot_a_path_reserved  <= 1'b0;
			slot_a_path_misconfig <= 1'b0;
		end else if (ce) begin
			slot_a_full_path     <= (path_mode == afe_slot_config_pkg::PATH_FULL);
			slot_a_amp_direct    <= (path_mode == afe_slot_config_pkg::PATH_DIRECT_BUF) ||
				(path_mode == afe_slot_config_pkg::PATH_DIRECT);
			slot_a_path_reserved <= (path_mode == afe_slot_config_pkg::PATH_RESERVED);
			case (path_mode)
				afe_slot_config_pkg::PATH_DIRECT_BUF: begin
					slot_a_path_misconfig <= ~slot_a_amplifier_settings_reg[`INT_AS_BUF_BIT];
				end
				afe_slot_config_pkg::PATH_DIRECT: begin
					slot_a_path_misconfig <= slot_a_amplifier_settings_reg[`INT_AS_BUF_BIT];
				end
				afe_slot_config_pkg::PATH_FULL: begin
					// Buffer mode belongs to the buffered direct path only
					slot_a_path_misconfig <= slot_a_amplifier_settings_reg[`INT_AS_BUF_BIT];
				end
				default: begin
					slot_a_path_misconfig <= 1'b0;
				end
			endcase
		end
	end

	// Status outputs
	assign slot_b_integ_reversed       = integ_reversed_reg;
	assign slot_b_window_open          = tif.window_open;
	assign slot_b_window_done          = tif.window_done;
	assign slot_b_front_end_mode_field = slot_b_front_end_mode_reg[15:10];

endmodule

`default_nettype wire

// [src/integration_window_timer.sv]
/*
  Integration window timer for time slot B: opens the window after the
  programmed offset, counted from the start of each LED pulse period, and
  holds it for the programmed width from the window opening.
  Assumes pulse_start is a one-cycle pulse synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afe_slot_config_defs.svh"

module integration_window_timer (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	window_timing_if.timer   tif
);

	afe_slot_config_pkg::window_state_type state_reg;  // Window phase
	logic [`TIME_W-1:0] elapsed_reg;   // Time since pulse start, ps
	logic [`TIME_W-1:0] open_at_reg;   // Latched window start, ps
	logic [`TIME_W-1:0] close_at_reg;  // Latched window end, ps
	logic [`TIME_W-1:0] open_at_next;
	logic [`TIME_W-1:0] close_at_next;
	logic               done_reg;      // Close pulse

	// Offset and width converted to picoseconds; the 31.25 ns step is not a whole
	// number of 50 ns cycles, so time is kept in ps and the edge lands on the
	// first clock at or past the exact instant
	always_comb begin
		open_at_next  = `TIME_W'({17'h0, tif.window_offset}) * `OFFSET_STEP_PS;
		close_at_next = open_at_next + `TIME_W'({23'h0, tif.window_width}) * `WIDTH_STEP_PS;
	end

	// Window sequencing; settings are latched at pulse start so a register
	// write in mid-window cannot tear the window in two
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg    <= afe_slot_config_pkg::WIN_IDLE;
			elapsed_reg  <= '0;
			open_at_reg  <= '0;
			close_at_reg <= '0;
			done_reg     <= 1'b0;
		end else if (ce) begin
			done_reg <= 1'b0;
			if (tif.pulse_start) begin
				// Each pulse period restarts the count
				elapsed_reg  <= '0;
				open_at_reg  <= open_at_next;
				close_at_reg <= close_at_next;
				state_reg    <= afe_slot_config_pkg::WIN_OFFSET;
			end else begin
				case (state_reg)
					afe_slot_config_pkg::WIN_IDLE: begin
						elapsed_reg <= elapsed_reg;
					end
					afe_slot_config_pkg::WIN_OFFSET: begin
						elapsed_reg <= elapsed_reg + `CLK_PERIOD_PS;
						// Zero width never opens
						if (elapsed_reg >= close_at_reg) begin
							state_reg <= afe_slot_config_pkg::WIN_IDLE;
							done_reg  <= 1'b1;
						end else if (elapsed_reg >= open_at_reg) begin
							state_reg <= afe_slot_config_pkg::WIN_INTEGRATE;
						end
					end
					afe_slot_config_pkg::WIN_INTEGRATE: begin
						elapsed_reg <= elapsed_reg + `CLK_PERIOD_PS;
						if (elapsed_reg >= close_at_reg) begin
							state_reg <= afe_slot_config_pkg::WIN_IDLE;
							done_reg  <= 1'b1;
						end
					end
					default: begin
						state_reg <= afe_slot_config_pkg::WIN_IDLE;
					end
				endcase
			end
		end
	end

	assign tif.window_open = (state_reg == afe_slot_config_pkg::WIN_INTEGRATE);
	assign tif.window_done = done_reg;

endmodule

`default_nettype wire

// [src/window_timing_if.sv]
/*
  Carrier between the configuration block and its integration window timer.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface window_timing_if;
	logic [10:0] window_offset;  // Offset in 31.25 ns steps
	logic [4:0]  window_width;   // Width in 1 us steps
	logic        pulse_start;    // One cycle at each LED pulse period start
	logic        window_open;    // High while integrating
	logic        window_done;    // One cycle when a window closes

	modport control (output window_offset, output window_width, output pulse_start,
		input window_open, input window_done);
	modport timer (input window_offset, input window_width, input pulse_start,
		output window_open, output window_done);
endinterface

`default_nettype wire
